/* File: rtl/serial_lane_and_source_control.sv */
// Lane control and converter-to-framer source control with its registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: Lane bit 2 set inverts every transmitted lane bit, clear sends as is.
// RL2: Lane control bit 0 set powers the lane down, clear keeps it running.
// RL3: Converter control bits 5 to 4 choose what feeds the framer input.
// RL4: Source code 00 passes live samples, and code 01 must not be used.
// RL5: Source code 10 feeds a fixed word, flag 0 and sample 10011011101010.
// RL6: Source code 11 feeds the pattern generator, typed by its type field.
// RL7: Converter control bit 0 set powers the converter core down.
// RL8: Lane mode picks encoder output, constant zero, toggle or pattern.
// RL9: The scrambler input bit picks frame assembly or pattern generator.
// RL10: Software writes reserved lane bit 1 as zero, unused bits as default.
module serial_lane_and_source_control
    import lane_src_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register access port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Pattern type from the pattern generator control register
    input wire logic [1:0] i_pattern_type,
    // Converter samples
    input wire logic i_sample_valid,
    input wire sample_word_t i_sample,
    output logic o_sample_ready,
    // Framer input
    output logic o_frm_valid,
    output sample_word_t o_frm_data,
    input wire logic i_frm_ready,
    // Scrambler input and lane
    input wire logic [OCTET_W-1:0] i_frame_octet,
    output logic [OCTET_W-1:0] o_scrambler_in,
    input wire logic [SYMBOL_W-1:0] i_enc_symbol,
    output logic [SYMBOL_W-1:0] o_lane_symbol,
    // Power-down controls
    output logic o_lane_powerdown,
    output logic o_converter_powerdown
);
    // ------------------------------------------------------------------
    // Pattern generator step
    // ------------------------------------------------------------------
    function automatic logic [LFSR_W-1:0] lfsr_step(
        input logic [LFSR_W-1:0] s,
        input logic [1:0] t
    );
        logic fb;
        fb = 1'b0;
        case (pattern_type_t'(t))
            PAT_P7: fb = s[6] ^ s[5];
            PAT_P9: fb = s[8] ^ s[4];
            PAT_P15: fb = s[14] ^ s[13];
            PAT_P23: fb = s[22] ^ s[17];
            default: fb = s[6] ^ s[5];
        endcase
        return {s[LFSR_W-2:0], fb};
    endfunction : lfsr_step

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] lane_ctrl_r, lane_ctrl_nxt;
    logic [7:0] conv_ctrl_r, conv_ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb begin
        lane_ctrl_nxt = lane_ctrl_r;
        conv_ctrl_nxt = conv_ctrl_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = i_reg_rd;
        // Unused bits are not stored, so they always read back as zero.
        if (i_reg_wr && i_reg_addr == ADDR_LANE_CTRL) begin
            lane_ctrl_nxt = i_reg_wdata & LANE_CTRL_MASK;
        end
        if (i_reg_wr && i_reg_addr == ADDR_CONV_CTRL) begin
            conv_ctrl_nxt = i_reg_wdata & CONV_CTRL_MASK;
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_LANE_CTRL: rdata_nxt = lane_ctrl_r;
                ADDR_CONV_CTRL: rdata_nxt = conv_ctrl_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            lane_ctrl_r <= LANE_CTRL_RST;
            conv_ctrl_r <= CONV_CTRL_RST;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            lane_ctrl_r <= lane_ctrl_nxt;
            conv_ctrl_r <= conv_ctrl_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    logic lane_powerdown, lane_inv, scr_sel, conv_pd;
    lane_mode_t lane_mode;
    source_sel_t src_sel;
    assign lane_powerdown = lane_ctrl_r[LANE_POWERDOWN_BIT]; // RL2
    assign lane_inv = lane_ctrl_r[LANE_POLARITY_INVERT_BIT]; // RL1
    assign scr_sel = lane_ctrl_r[SCR_IN_BIT]; // RL9
    assign lane_mode = lane_mode_t'(lane_ctrl_r[LANE_MODE_LO+:2]); // RL8
    assign src_sel = source_sel_t'(conv_ctrl_r[CONV_SRC_LO+:2]); // RL3
    assign conv_pd = conv_ctrl_r[CONV_PD_BIT]; // RL7

    // ------------------------------------------------------------------
    // Source selection and two-entry buffer
    // ------------------------------------------------------------------
    logic [LFSR_W-1:0] lfsr_r, lfsr_nxt;
    sample_word_t src_word;
    logic src_valid, push, pop;
    logic out_valid_r, out_valid_nxt, skid_valid_r, skid_valid_nxt;
    sample_word_t out_data_r, out_data_nxt, skid_data_r, skid_data_nxt;
    logic ready_r, ready_nxt;

    always_comb begin
        lfsr_nxt = lfsr_step(lfsr_r, i_pattern_type); // RL6
        case (src_sel)
            SRC_LIVE: begin
                // A powered-down core produces no samples to forward.
                src_valid = i_sample_valid && !conv_pd; // RL4 RL7
                src_word = i_sample;
            end
            SRC_DUMMY: begin
                src_valid = 1'b1;
                src_word.out_of_range_flag = 1'b0; // RL5
                src_word.value = DUMMY_SAMPLE; // RL5
            end
            SRC_PATTERN: begin
                src_valid = 1'b1;
                src_word = sample_word_t'(lfsr_r[SAMPLE_W:0]); // RL6
            end
            default: begin
                // The unused code forwards nothing.
                src_valid = 1'b0; // RL4
                src_word = '0;
            end
        endcase
        push = src_valid && ready_r;
        pop = out_valid_r && i_frm_ready;
        out_valid_nxt = out_valid_r;
        out_data_nxt = out_data_r;
        skid_valid_nxt = skid_valid_r;
        skid_data_nxt = skid_data_r;
        if (!out_valid_r || pop) begin
            out_valid_nxt = skid_valid_r || push;
            out_data_nxt = skid_valid_r ? skid_data_r : src_word;
            skid_valid_nxt = 1'b0;
        end else if (push) begin
            // The second entry catches the word taken while the framer stalls.
            skid_valid_nxt = 1'b1;
            skid_data_nxt = src_word;
        end
        ready_nxt = !skid_valid_nxt;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            lfsr_r <= LFSR_SEED;
            out_valid_r <= 1'b0;
            out_data_r <= '0;
            skid_valid_r <= 1'b0;
            skid_data_r <= '0;
            ready_r <= 1'b0;
        end else begin
            lfsr_r <= lfsr_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
            skid_valid_r <= skid_valid_nxt;
            skid_data_r <= skid_data_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Lane output stage
    // ------------------------------------------------------------------
    logic toggle_r, toggle_nxt;
    logic [SYMBOL_W-1:0] lane_r, lane_nxt;
    logic [OCTET_W-1:0] scr_r, scr_nxt;
    logic lane_powerdown_r, conv_pd_r;

    always_comb begin
        toggle_nxt = !toggle_r;
        case (lane_mode)
            LANE_NORMAL: lane_nxt = i_enc_symbol; // RL8
            LANE_CONST: lane_nxt = SYMBOL_ZERO; // RL8
            LANE_TOGGLE: lane_nxt = {SYMBOL_W{toggle_r}}; // RL8
            LANE_PATTERN: lane_nxt = lfsr_r[SYMBOL_W-1:0]; // RL8
            default: lane_nxt = SYMBOL_ZERO;
        endcase
        if (lane_inv) begin
            lane_nxt = ~lane_nxt; // RL1
        end
        // A powered-down lane is held quiet whatever its polarity.
        if (lane_powerdown) begin
            lane_nxt = SYMBOL_ZERO; // RL2
        end
        scr_nxt = scr_sel ? lfsr_r[OCTET_W-1:0] : i_frame_octet; // RL9
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            toggle_r <= 1'b0;
            lane_r <= SYMBOL_ZERO;
            scr_r <= '0;
            lane_powerdown_r <= 1'b0;
            conv_pd_r <= 1'b0;
        end else begin
            toggle_r <= toggle_nxt;
            lane_r <= lane_nxt;
            scr_r <= scr_nxt;
            lane_powerdown_r <= lane_powerdown;
            conv_pd_r <= conv_pd;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_sample_ready = ready_r;
    assign o_frm_valid = out_valid_r;
    assign o_frm_data = out_data_r;
    assign o_scrambler_in = scr_r;
    assign o_lane_symbol = lane_r;
    assign o_lane_powerdown = lane_powerdown_r;
    assign o_converter_powerdown = conv_pd_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_lane_polarity_invert_inv: assert property ( // RL1
        !lane_powerdown && lane_inv && lane_mode == LANE_CONST |=>
        o_lane_symbol == SYMBOL_ONES)
        else $error("inverted constant lane is not all ones");
    chk_lane_powerdown_quiet: assert property ( // RL2
        lane_powerdown |=> o_lane_symbol == SYMBOL_ZERO && o_lane_powerdown)
        else $error("powered-down lane is not quiet");
    chk_src_field_wr: assert property ( // RL3
        i_reg_wr && i_reg_addr == ADDR_CONV_CTRL |=>
        src_sel == source_sel_t'($past(i_reg_wdata[CONV_SRC_LO+:2])))
        else $error("source field did not take the written value");
    chk_unused_src_idle: assert property ( // RL4
        src_sel == SRC_UNUSED |-> !push)
        else $error("unused source code forwarded a word");
    chk_dummy_word: assert property ( // RL5
        src_sel == SRC_DUMMY && push && !out_valid_r |=>
        o_frm_valid && o_frm_data == {1'b0, DUMMY_SAMPLE})
        else $error("dummy word is wrong");
    chk_pattern_src: assert property ( // RL6
        src_sel == SRC_PATTERN && push && !out_valid_r |=>
        o_frm_data == sample_word_t'($past(lfsr_r[SAMPLE_W:0])))
        else $error("pattern source word is wrong");
    chk_conv_pd_live: assert property ( // RL7
        src_sel == SRC_LIVE && conv_pd |-> !push ##1 o_converter_powerdown)
        else $error("powered-down core forwarded a sample");
    chk_lane_toggle: assert property ( // RL8
        (!lane_powerdown && !lane_inv && lane_mode == LANE_TOGGLE)[*2] |=>
        o_lane_symbol != $past(o_lane_symbol))
        else $error("toggle lane did not alternate");
    chk_lane_normal: assert property ( // RL8
        !lane_powerdown && !lane_inv && lane_mode == LANE_NORMAL |=>
        o_lane_symbol == $past(i_enc_symbol))
        else $error("normal lane does not follow the encoder");
    chk_scr_select: assert property ( // RL9
        !scr_sel |=> o_scrambler_in == $past(i_frame_octet))
        else $error("scrambler input does not follow frame assembly");
    chk_stall_holds: assert property (
        o_frm_valid && !i_frm_ready |=> o_frm_valid && $stable(o_frm_data))
        else $error("framer word changed during a stall");
    chk_no_overflow: assert property (
        o_frm_valid && !i_frm_ready && !o_sample_ready |=> !o_sample_ready)
        else $error("buffer accepts while full");

    cov_dummy_flow: cover property (src_sel == SRC_DUMMY && pop);
    cov_stall_fill: cover property (push && out_valid_r && !i_frm_ready);
    cov_pattern_lane: cover property (lane_mode == LANE_PATTERN && lane_inv);
    cov_live_sample: cover property (src_sel == SRC_LIVE && push ##1 pop);
endmodule : serial_lane_and_source_control
`default_nettype wire

/* File: inc/lane_src_pkg.sv */
// Constants and types shared by the serial lane and source control block.
package lane_src_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_LANE_CTRL = 16'h0871;
    localparam logic [15:0] ADDR_CONV_CTRL = 16'h0891;
    localparam int LANE_POWERDOWN_BIT = 0;
    localparam int LANE_RSVD_BIT = 1;
    localparam int LANE_POLARITY_INVERT_BIT = 2;
    localparam int LANE_MODE_LO = 4;
    localparam int SCR_IN_BIT = 6;
    localparam int CONV_PD_BIT = 0;
    localparam int CONV_SRC_LO = 4;
    localparam logic [7:0] LANE_CTRL_RST = 8'h00;
    localparam logic [7:0] CONV_CTRL_RST = 8'h00;
    localparam logic [7:0] LANE_CTRL_MASK = 8'h77;
    localparam logic [7:0] CONV_CTRL_MASK = 8'h31;
    // ------------------------------------------------------------------
    // Data widths and fixed words
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 14;
    localparam int SYMBOL_W = 10;
    localparam int OCTET_W = 8;
    localparam int LFSR_W = 23;
    localparam logic [SAMPLE_W-1:0] DUMMY_SAMPLE = 14'h26ea;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h7fffff;
    localparam logic [SYMBOL_W-1:0] SYMBOL_ZERO = 10'h000;
    localparam logic [SYMBOL_W-1:0] SYMBOL_ONES = 10'h3ff;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic out_of_range_flag;
        logic [SAMPLE_W-1:0] value;
    } sample_word_t;
    typedef enum logic [1:0] {
        SRC_LIVE = 2'b00,
        SRC_UNUSED = 2'b01,
        SRC_DUMMY = 2'b10,
        SRC_PATTERN = 2'b11
    } source_sel_t;
    typedef enum logic [1:0] {
        LANE_NORMAL = 2'b00,
        LANE_CONST = 2'b01,
        LANE_TOGGLE = 2'b10,
        LANE_PATTERN = 2'b11
    } lane_mode_t;
    typedef enum logic [1:0] {
        PAT_P7 = 2'b00,
        PAT_P9 = 2'b01,
        PAT_P15 = 2'b10,
        PAT_P23 = 2'b11
    } pattern_type_t;
endpackage : lane_src_pkg

/* File: dv/frm_sink.sv */
// Framer-side sink model that takes words at a chosen pace.
`timescale 1ns/1ps
`default_nettype none
module frm_sink
    import lane_src_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Pace: 0 always ready, 1 one cycle in three, 2 stalled
    input wire logic [1:0] i_pace,
    // Framer word stream
    input wire logic i_valid,
    input wire sample_word_t i_data,
    output logic o_ready
);
    sample_word_t got[$];
    int unsigned cnt = 0;
    // Ready moves just after the edge, so the design sees it settled.
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_data);
        end
        cnt = cnt + 1;
        #1;
        o_ready = (i_pace == 2'h0) || (i_pace == 2'h1 && cnt % 3 == 0);
    end
endmodule : frm_sink
`default_nettype wire

/* File: dv/serial_lane_and_source_control_tb.sv */
// Testbench for the serial lane and source control block.
`timescale 1ns/1ps
`default_nettype none
module serial_lane_and_source_control_tb
    import lane_src_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] ptype = 2'h0;
    logic sv = 1'b0;
    sample_word_t smp = '0;
    logic sready, fv, fr, lpd, cpd;
    sample_word_t fd;
    logic [7:0] oct = 8'ha5;
    logic [7:0] scr;
    logic [9:0] enc = 10'h155;
    logic [9:0] lsym, t0;
    logic [7:0] s0;
    logic [1:0] pace = 2'h2;
    int checks = 0;
    int err_total = 0;
    logic [7:0] lw [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h01, 8'h05};
    logic [9:0] le [6] = '{10'h155, 10'h2aa, 10'h000, 10'h3ff, 10'h000,
        10'h000};
    logic [7:0] cw [4] = '{8'h01, 8'h10, 8'h30, 8'h20};
    logic cv [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

    always #50 i_clk = ~i_clk;

    serial_lane_and_source_control i_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_pattern_type(ptype),
        .i_sample_valid(sv), .i_sample(smp), .o_sample_ready(sready),
        .o_frm_valid(fv), .o_frm_data(fd), .i_frm_ready(fr),
        .i_frame_octet(oct), .o_scrambler_in(scr), .i_enc_symbol(enc),
        .o_lane_symbol(lsym), .o_lane_powerdown(lpd),
        .o_converter_powerdown(cpd));

    frm_sink i_sink (.i_clk(i_clk), .i_pace(pace), .i_valid(fv),
        .i_data(fd), .o_ready(fr));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        wr = 1'b1;
        addr = a;
        wdata = d;
        cyc(1);
        wr = 1'b0;
    endtask : wr_reg

    // The answer stands one cycle only, so it is looked at right away.
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        #1;
        rd = 1'b1;
        addr = a;
        cyc(1);
        rd = 1'b0;
        chk("rvalid", rvalid, 1'b1);
        chk("rdata", rdata, exp);
    endtask : rd_reg

    task automatic send(input sample_word_t w);
        sv = 1'b1;
        smp = w;
        for (int n = 0; sready !== 1'b1; n++) begin
            if (n == 50) begin
                err_total++;
                report_and_stop();
            end
            cyc(1);
        end
        cyc(1);
    endtask : send

    function automatic sample_word_t mk(input int i);
        mk = {i[0], 14'(i) * 14'h0123 + 14'h0005};
    endfunction : mk

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        chk("lane_powerdown rst", lpd, 1'b0);
        chk("conv pd rst", cpd, 1'b0);
        rd_reg(ADDR_LANE_CTRL, 8'h00);
        rd_reg(ADDR_CONV_CTRL, 8'h00);
        // ------------------------------------------------------------
        // Lane polarity, modes and power-down
        // ------------------------------------------------------------
        for (int i = 0; i < 6; i++) begin
            wr_reg(ADDR_LANE_CTRL, lw[i]);
            cyc(2);
            chk("lane symbol", lsym, le[i]);
            chk("lane_powerdown", lpd, lw[i][0]);
            chk("scrambler in", scr, oct);
        end
        wr_reg(ADDR_LANE_CTRL, 8'h20);
        cyc(2);
        t0 = lsym;
        cyc(1);
        chk("toggle", lsym ^ t0, 10'h3ff);
        wr_reg(ADDR_LANE_CTRL, 8'h70);
        cyc(2);
        t0 = lsym;
        s0 = scr;
        cyc(1);
        chk("pattern", lsym !== t0 && scr !== s0, 1'b1);
        rd_reg(ADDR_LANE_CTRL, 8'h70);
        // Unused bits and a foreign address are refused.
        wr_reg(ADDR_LANE_CTRL, 8'h88);
        wr_reg(16'h0872, 8'h55);
        rd_reg(16'h0872, 8'h00);
        rd_reg(ADDR_LANE_CTRL, 8'h00);
        // ------------------------------------------------------------
        // Live samples through a stalled, then slow, framer
        // ------------------------------------------------------------
        i_sink.got.delete();
        for (int i = 0; i < 2; i++) send(mk(i));
        sv = 1'b0;
        cyc(2);
        chk("buffer full", sready, 1'b0);
        pace = 2'h1;
        for (int i = 2; i < 6; i++) send(mk(i));
        sv = 1'b0;
        cyc(20);
        chk("live count", 16'(i_sink.got.size()), 16'h0006);
        for (int i = 0; i < 6; i++) begin
            chk("live word", i_sink.got[i], mk(i));
        end
        // ------------------------------------------------------------
        // Source codes and converter power-down
        // ------------------------------------------------------------
        sv = 1'b1;
        pace = 2'h0;
        for (int i = 0; i < 4; i++) begin
            ptype = 2'(i);
            wr_reg(ADDR_CONV_CTRL, cw[i]);
            cyc(4);
            i_sink.got.delete();
            cyc(8);
            chk("source flow", i_sink.got.size() > 0, cv[i]);
            chk("conv pd", cpd, cw[i][0]);
        end
        chk("dummy word", i_sink.got[$], 15'h26ea);
        rd_reg(ADDR_CONV_CTRL, 8'h20);
        wr_reg(ADDR_CONV_CTRL, 8'hce);
        rd_reg(ADDR_CONV_CTRL, 8'h00);
        report_and_stop();
    end
endmodule : serial_lane_and_source_control_tb
`default_nettype wire
